/* File: logic/ccsb_device.sv */
// config bank end: register store, reference decode and output routing
`timescale 1ns/1ps
`default_nettype none
module ccsb_device (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // register link
    ccsb_if.device          bus,
    // aux routing control
    input  wire logic [1:0] auxOneSrc,
    input  wire logic       auxOneEn,
    input  wire logic [1:0] auxTwoSrc,
    input  wire logic       auxTwoEn,
    // decoded configuration
    output logic [7:0]      pllCoeff [6],
    output logic [7:0]      synthSelect,
    output logic            synthOutFirstOn,
    output logic            extClockMode,
    output logic            vcxoEnabled,
    output logic [7:0]      loadSetting,
    output logic [1:0]      auxOneSel,
    output logic            auxOneOn,
    output logic [1:0]      auxTwoSel,
    output logic            auxTwoOn
);
    localparam int N = ccsb_pkg::NUM_REGS;

    logic [7:0] regQ [N];
    logic [N-1:0] hit;
    logic [7:0] rdDataQ;
    logic       rdValidQ;
    logic [1:0] auxOneSelQ, auxTwoSelQ;
    logic       auxOneOnQ, auxTwoOnQ;
    logic       synthOnQ, extModeQ, vcxoQ;

    //--------------------------------------------------------------------------
    // register store
    //--------------------------------------------------------------------------
    // one flop byte per register; reset reloads defaults (volatile store)
    for (genvar i = 0; i < N; i++) begin : g_reg
        assign hit[i] = (bus.addr == ccsb_pkg::REG_ADDR[i]);
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                regQ[i] <= ccsb_pkg::REG_RST[i];
            end else if (bus.wrEn && hit[i]) begin
                regQ[i] <= bus.wrData; // whole byte only
            end
        end
    end

    // read mux; unmapped addresses read zero
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                rdMux = regQ[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdDataQ  <= 8'h00;
            rdValidQ <= 1'b0;
        end else begin
            rdValidQ <= bus.rdEn;
            if (bus.rdEn) begin
                rdDataQ <= rdMux;
            end
        end
    end
    assign bus.rdData  = rdDataQ;
    assign bus.rdValid = rdValidQ;

    //--------------------------------------------------------------------------
    // decoded configuration
    //--------------------------------------------------------------------------
    // outputs read straight from the register flops
    for (genvar k = 0; k < 6; k++) begin : g_coeff
        assign pllCoeff[k] = regQ[k];
    end
    assign synthSelect = regQ[8];
    assign loadSetting = regQ[7];
    // select code 8D is the off state of the first synthesized output
    wire logic synthOnD  = (regQ[8] != ccsb_pkg::SEL_OFF);
    // 89 in the mode byte takes the reference from the input pin
    wire logic extModeD  = (regQ[6] == ccsb_pkg::REFMODE_EXT_CLOCK);
    // 3A under mode 89 is the external code, so a pull code only counts in crystal mode
    wire logic pullLoadD = (regQ[7] == ccsb_pkg::PULL_3A) || (regQ[7] == ccsb_pkg::PULL_2A)
                           || (regQ[7] == ccsb_pkg::PULL_41) || (regQ[7] == ccsb_pkg::PULL_39);
    wire logic vcxoD     = !extModeD && pullLoadD;

    // flags registered so each output leaves a flop; they trail the store by a cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            synthOnQ <= 1'b0; // default select is the off code
            extModeQ <= 1'b0;
            vcxoQ    <= 1'b0; // default load 67 is a plain crystal
        end else begin
            synthOnQ <= synthOnD;
            extModeQ <= extModeD;
            vcxoQ    <= vcxoD;
        end
    end
    assign synthOutFirstOn = synthOnQ;
    assign extClockMode    = extModeQ;
    assign vcxoEnabled     = vcxoQ;

    //--------------------------------------------------------------------------
    // aux output routing
    //--------------------------------------------------------------------------
    // reset leaves aux two on the reference, aux one off
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            auxOneSelQ <= ccsb_pkg::AUX_SRC_REF;
            auxOneOnQ  <= ccsb_pkg::AUX_ONE_RST_EN;
            auxTwoSelQ <= ccsb_pkg::AUX_SRC_REF;
            auxTwoOnQ  <= ccsb_pkg::AUX_TWO_RST_EN;
        end else begin
            auxOneSelQ <= auxOneSrc;
            auxOneOnQ  <= auxOneEn;
            auxTwoSelQ <= auxTwoSrc;
            auxTwoOnQ  <= auxTwoEn;
        end
    end
    assign auxOneSel = auxOneSelQ;
    assign auxOneOn  = auxOneOnQ;
    assign auxTwoSel = auxTwoSelQ;
    assign auxTwoOn  = auxTwoOnQ;
endmodule
`default_nettype wire

/* File: logic/ccsb_pkg.sv */
// constants and types shared by both ends of the clock synth config bank
//------------------------------------------------------------------------------
// Function
// - external clock: mode 89, load 3A
// - reset reference: mode 88, load 67
// - plain crystal: mode 88, load by capacitance
// - pullable crystal: mode 88, qualified load code
// - host writes whole merged bytes only
// - reset: coeff two 88, five 44, select 8D
// - frequency set: six coefficients, then output select
// - aux outputs copy any primary or reference
// - VCXO off needs non-VCXO register values
// - contents volatile, defaults restored at reset
// - reset: only aux two carries reference
//------------------------------------------------------------------------------
package ccsb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 9;

    // register offsets
    localparam logic [7:0] ADDR_PLL_C_COEFF_0      = 8'h0A;
    localparam logic [7:0] ADDR_PLL_C_COEFF_1      = 8'h0B;
    localparam logic [7:0] ADDR_PLL_C_COEFF_2      = 8'h0C;
    localparam logic [7:0] ADDR_PLL_C_COEFF_3      = 8'h0D;
    localparam logic [7:0] ADDR_PLL_C_COEFF_4      = 8'h0E;
    localparam logic [7:0] ADDR_PLL_C_COEFF_5      = 8'h0F;
    localparam logic [7:0] ADDR_REFERENCE_MODE_CFG = 8'h16;
    localparam logic [7:0] ADDR_CRYSTAL_LOAD_CFG   = 8'h17;
    localparam logic [7:0] ADDR_OUT_C_SELECT_DRIVE = 8'h48;

    // reset values; unlisted coefficients come up as zero
    localparam logic [7:0] RST_PLL_C_COEFF_0      = 8'h00;
    localparam logic [7:0] RST_PLL_C_COEFF_1      = 8'h00;
    localparam logic [7:0] RST_PLL_C_COEFF_2      = 8'h88;
    localparam logic [7:0] RST_PLL_C_COEFF_3      = 8'h00;
    localparam logic [7:0] RST_PLL_C_COEFF_4      = 8'h00;
    localparam logic [7:0] RST_PLL_C_COEFF_5      = 8'h44;
    localparam logic [7:0] RST_REFERENCE_MODE_CFG = 8'h88;
    localparam logic [7:0] RST_CRYSTAL_LOAD_CFG   = 8'h67;
    localparam logic [7:0] RST_OUT_C_SELECT_DRIVE = 8'h8D;

    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        ADDR_PLL_C_COEFF_0, ADDR_PLL_C_COEFF_1, ADDR_PLL_C_COEFF_2,
        ADDR_PLL_C_COEFF_3, ADDR_PLL_C_COEFF_4, ADDR_PLL_C_COEFF_5,
        ADDR_REFERENCE_MODE_CFG, ADDR_CRYSTAL_LOAD_CFG, ADDR_OUT_C_SELECT_DRIVE};
    localparam logic [7:0] REG_RST [NUM_REGS] = '{
        RST_PLL_C_COEFF_0, RST_PLL_C_COEFF_1, RST_PLL_C_COEFF_2,
        RST_PLL_C_COEFF_3, RST_PLL_C_COEFF_4, RST_PLL_C_COEFF_5,
        RST_REFERENCE_MODE_CFG, RST_CRYSTAL_LOAD_CFG, RST_OUT_C_SELECT_DRIVE};

    // reference mode and crystal load codes
    localparam logic [7:0] REFMODE_EXT_CLOCK = 8'h89;
    localparam logic [7:0] REFMODE_CRYSTAL   = 8'h88;
    localparam logic [7:0] LOAD_EXT_CLOCK    = 8'h3A;
    localparam logic [7:0] LOAD_10P7         = 8'h4F;
    localparam logic [7:0] LOAD_12P0         = 8'h5F;
    localparam logic [7:0] LOAD_12P6         = 8'h67;
    localparam logic [7:0] LOAD_14P0         = 8'h77;
    localparam logic [7:0] PULL_3A           = 8'h3A;
    localparam logic [7:0] PULL_2A           = 8'h2A;
    localparam logic [7:0] PULL_41           = 8'h41;
    localparam logic [7:0] PULL_39           = 8'h39;

    // 48 kHz audio family PLL bytes and select codes
    localparam logic [7:0] AUD48_PLL [6] = '{8'h17, 8'h3E, 8'hD0, 8'h1C, 8'h06, 8'h64};
    localparam logic [7:0] SEL_OFF       = 8'h8D;
    localparam logic [7:0] SEL_6M144     = 8'hA5;

    // aux output source field and encodings
    localparam logic [1:0] AUX_SRC_REF   = 2'h0;
    localparam logic [1:0] AUX_SRC_C     = 2'h1;
    localparam logic [1:0] AUX_SRC_D     = 2'h2;
    localparam logic [1:0] AUX_SRC_E     = 2'h3;
    localparam logic AUX_ONE_RST_EN      = 1'b0;
    localparam logic AUX_TWO_RST_EN      = 1'b1;

    // host sequencer commands
    typedef enum logic [1:0] {
        CCSB_CMD_RAW,
        CCSB_CMD_EXT_CLOCK,
        CCSB_CMD_CRYSTAL,
        CCSB_CMD_PULLABLE
    } ccsb_cmd_t;
endpackage

/* File: logic/ccsb_if.sv */
// register write/read link between host and config bank
`timescale 1ns/1ps
`default_nettype none
interface ccsb_if;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic       rdValid;

    modport device (input wrEn, rdEn, addr, wrData, output rdData, rdValid);
    modport host   (output wrEn, rdEn, addr, wrData, input rdData, rdValid);
endinterface
`default_nettype wire

/* File: logic/ccsb_host.sv */
// host end: issues single writes or reads, or reference-mode byte pairs
`timescale 1ns/1ps
`default_nettype none
module ccsb_host (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // user request
    input  wire logic       reqValid,
    input  wire ccsb_pkg::ccsb_cmd_t reqCmd,
    input  wire logic       reqRead,
    input  wire logic [7:0] reqAddr,
    input  wire logic [7:0] reqData,
    output logic            reqReady,
    output logic [7:0]      rspData,
    output logic            rspValid,
    // register link
    ccsb_if.host            bus
);
    typedef enum logic [1:0] {ST_IDLE, ST_SECOND} ccsb_st_t;
    ccsb_st_t   stQ;
    logic       wrEnQ, rdEnQ;
    logic [7:0] addrQ, dataQ, secondQ, rspDataQ;
    logic       rspValidQ;

    // reference commands fix the mode byte; data picks the load byte, except external clock forces 3A
    wire logic [7:0] modeByte = (reqCmd == ccsb_pkg::CCSB_CMD_EXT_CLOCK)
                                ? ccsb_pkg::REFMODE_EXT_CLOCK : ccsb_pkg::REFMODE_CRYSTAL;
    wire logic [7:0] loadByte = (reqCmd == ccsb_pkg::CCSB_CMD_EXT_CLOCK)
                                ? ccsb_pkg::LOAD_EXT_CLOCK : reqData;
    wire logic       isPair   = (reqCmd != ccsb_pkg::CCSB_CMD_RAW);
    wire logic       take     = reqValid && (stQ == ST_IDLE);

    // pair writes go mode byte first then load byte, whole bytes only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stQ     <= ST_IDLE;
            wrEnQ   <= 1'b0;
            rdEnQ   <= 1'b0;
            addrQ   <= 8'h00;
            dataQ   <= 8'h00;
            secondQ <= 8'h00;
        end else begin
            wrEnQ <= 1'b0;
            rdEnQ <= 1'b0;
            unique case (stQ)
                ST_IDLE: begin
                    if (take && isPair) begin
                        wrEnQ   <= 1'b1;
                        addrQ   <= ccsb_pkg::ADDR_REFERENCE_MODE_CFG;
                        dataQ   <= modeByte;
                        secondQ <= loadByte;
                        stQ     <= ST_SECOND;
                    end else if (take) begin
                        wrEnQ <= !reqRead;
                        rdEnQ <= reqRead;
                        addrQ <= reqAddr;
                        dataQ <= reqData;
                    end
                end
                ST_SECOND: begin
                    wrEnQ <= 1'b1;
                    addrQ <= ccsb_pkg::ADDR_CRYSTAL_LOAD_CFG;
                    dataQ <= secondQ;
                    stQ   <= ST_IDLE;
                end
            endcase
        end
    end

    // read answers reach rspValid two cycles after the strobe, one cycle after rdValid
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rspDataQ  <= 8'h00;
            rspValidQ <= 1'b0;
        end else begin
            rspValidQ <= bus.rdValid;
            if (bus.rdValid) begin
                rspDataQ <= bus.rdData;
            end
        end
    end

    assign reqReady   = (stQ == ST_IDLE);
    assign rspData    = rspDataQ;
    assign rspValid   = rspValidQ;
    assign bus.wrEn   = wrEnQ;
    assign bus.rdEn   = rdEnQ;
    assign bus.addr   = addrQ;
    assign bus.wrData = dataQ;
endmodule
`default_nettype wire

/* File: dv/ccsb_props.sv */
// link checker for the clock synth config bank register path
`timescale 1ns/1ps
`default_nettype none
module ccsb_props (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // register link
    input wire logic       wrEn,
    input wire logic       rdEn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic       rdValid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    //--------------------------------------------------------------------------
    // helper state
    //--------------------------------------------------------------------------
    logic fresh_q;
    // high from reset until the first write, so reads then must show defaults
    always_ff @(posedge clk_sys) fresh_q <= sys_rst | (fresh_q & ~wrEn);
    //--------------------------------------------------------------------------
    // properties
    //--------------------------------------------------------------------------
    chk_rd_answer_lag: assert property (rdEn |=> rdValid)
        else $error("read answer missing one cycle after strobe");
    chk_rd_no_spurious: assert property (rdValid |-> $past(rdEn))
        else $error("read answer without a strobe");
    chk_rd_data_hold: assert property (!rdValid && !$past(sys_rst) |-> $stable(rdData))
        else $error("read data moved without a read");
    chk_wr_then_rd: assert property (wrEn ##1 (rdEn && !wrEn && addr == $past(addr))
        |=> rdData == $past(wrData, 2)) else $error("read back differs from byte written");
    chk_rst_refmode: assert property (fresh_q && rdEn && addr == 8'h16 |=> rdData == 8'h88)
        else $error("reference mode default wrong");
    chk_rst_load: assert property (fresh_q && rdEn && addr == 8'h17 |=> rdData == 8'h67)
        else $error("crystal load default wrong");
    chk_rst_coeff_two: assert property (fresh_q && rdEn && addr == 8'h0C |=> rdData == 8'h88)
        else $error("coefficient two default wrong");
    chk_rst_coeff_five: assert property (fresh_q && rdEn && addr == 8'h0F |=> rdData == 8'h44)
        else $error("coefficient five default wrong");
    chk_rst_out_off: assert property (fresh_q && rdEn && addr == 8'h48 |=> rdData == 8'h8D)
        else $error("output select default wrong");
    chk_ext_pair: assert property (wrEn && addr == 8'h16 && wrData == 8'h89
        |=> wrEn && addr == 8'h17 && wrData == 8'h3A) else $error("external pair incomplete");
endmodule
`default_nettype wire

/* File: dv/tb_clock_synth_config_bank.sv */
// self-checking bench joining host end and config bank end
`timescale 1ns/1ps
`default_nettype none
module tb_clock_synth_config_bank;
    //--------------------------------------------------------------------------
    // signals and ends
    //--------------------------------------------------------------------------
    logic                clk_sys, sys_rst, reqValid, reqRead, reqReady, rspValid;
    logic                auxOneEn, auxTwoEn, synthOutFirstOn, extClockMode, vcxoEnabled;
    logic                auxOneOn, auxTwoOn;
    logic [1:0]          auxOneSrc, auxTwoSrc, auxOneSel, auxTwoSel;
    logic [7:0]          reqAddr, reqData, rspData, synthSelect, loadSetting;
    logic [7:0]          pllCoeff [6];
    ccsb_pkg::ccsb_cmd_t reqCmd;
    int                  err_count, comparisons;
    ccsb_if link ();
    ccsb_device i_ccsb_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(link),
        .auxOneSrc(auxOneSrc), .auxOneEn(auxOneEn), .auxTwoSrc(auxTwoSrc), .auxTwoEn(auxTwoEn),
        .pllCoeff(pllCoeff), .synthSelect(synthSelect), .synthOutFirstOn(synthOutFirstOn),
        .extClockMode(extClockMode), .vcxoEnabled(vcxoEnabled), .loadSetting(loadSetting),
        .auxOneSel(auxOneSel), .auxOneOn(auxOneOn), .auxTwoSel(auxTwoSel), .auxTwoOn(auxTwoOn));
    ccsb_host i_ccsb_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .reqValid(reqValid),
        .reqCmd(reqCmd), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
        .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid), .bus(link));
    ccsb_props i_ccsb_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .wrEn(link.wrEn),
        .rdEn(link.rdEn), .addr(link.addr), .wrData(link.wrData), .rdData(link.rdData),
        .rdValid(link.rdValid));
    //--------------------------------------------------------------------------
    // shared tasks
    //--------------------------------------------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // sampled at the falling edge, where the flag is settled for the next rising one
    // rsp picks the response flag, otherwise the request ready flag is watched
    task automatic wait_hi(input bit rsp);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while ((rsp ? rspValid : reqReady) !== 1'b1 && n < 40);
        if ((rsp ? rspValid : reqReady) !== 1'b1) begin
            err_count++;
            final_report();
        end
    endtask
    // request stays up until taken; release is left to idle so requests can abut
    task automatic req(input ccsb_pkg::ccsb_cmd_t c, input logic r, input logic [7:0] a, d);
        reqValid <= 1'b1;
        reqCmd   <= c;
        reqRead  <= r;
        reqAddr  <= a;
        reqData  <= d;
        wait_hi(1'b0);
        @(posedge clk_sys);
    endtask
    task automatic idle;
        reqValid <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, d);
        req(ccsb_pkg::CCSB_CMD_RAW, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, exp, input string what);
        req(ccsb_pkg::CCSB_CMD_RAW, 1'b1, a, 8'h00);
        idle();
        wait_hi(1'b1);
        check(what, rspData, exp);
        @(posedge clk_sys);
    endtask
    //--------------------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------------------
    task automatic t_defaults;
        for (int i = 0; i < ccsb_pkg::NUM_REGS; i++) begin
            rd(ccsb_pkg::REG_ADDR[i], ccsb_pkg::REG_RST[i], "default");
        end
        check("outOn", 8'(synthOutFirstOn), 8'h00);
        check("extDefault", 8'(extClockMode), 8'h00);
        check("vcxo", 8'(vcxoEnabled), 8'h00);
        check("loadDefault", loadSetting, ccsb_pkg::LOAD_12P6);
        check("selDefault", synthSelect, ccsb_pkg::SEL_OFF);
        check("auxTwoOn", 8'(auxTwoOn), 8'h01);
        check("auxOneOn", 8'(auxOneOn), 8'h00);
    endtask
    // external pair first, then every plain and every pullable load code
    task automatic t_modes;
        logic [7:0] loads [8] = '{8'h4F, 8'h5F, 8'h67, 8'h77, 8'h3A, 8'h2A, 8'h41, 8'h39};
        req(ccsb_pkg::CCSB_CMD_EXT_CLOCK, 1'b0, 8'h00, 8'h00);
        idle();
        rd(8'h16, 8'h89, "extMode");
        rd(8'h17, 8'h3A, "extLoad");
        check("extClock", 8'(extClockMode), 8'h01);
        check("extVcxo", 8'(vcxoEnabled), 8'h00);
        for (int i = 0; i < 8; i++) begin
            req(i < 4 ? ccsb_pkg::CCSB_CMD_CRYSTAL : ccsb_pkg::CCSB_CMD_PULLABLE, 1'b0, 8'h00,
                loads[i]);
            idle();
            rd(8'h16, 8'h88, "xtalMode");
            check("load", loadSetting, loads[i]);
            check("xtalExt", 8'(extClockMode), 8'h00);
            check("vcxo", 8'(vcxoEnabled), 8'(i >= 4));
        end
    endtask
    // audio set written back to back, then the output turned off again
    task automatic t_audio;
        for (int i = 0; i < 6; i++) begin
            wr(8'h0A + 8'(i), ccsb_pkg::AUD48_PLL[i]);
        end
        // select byte carries drive bits too, so it goes as one merged byte
        wr(8'h48, 8'hA5);
        rd(8'h48, 8'hA5, "select");
        for (int i = 0; i < 6; i++) begin
            check("coeff", pllCoeff[i], ccsb_pkg::AUD48_PLL[i]);
        end
        check("synthSel", synthSelect, ccsb_pkg::SEL_6M144);
        check("outOn", 8'(synthOutFirstOn), 8'h01);
        wr(8'h48, 8'h8D);
        rd(8'h48, 8'h8D, "off");
        check("outOff", 8'(synthOutFirstOn), 8'h00);
        check("synthSelOff", synthSelect, ccsb_pkg::SEL_OFF);
    endtask
    // unmapped place, then boundary bytes read straight back
    task automatic t_edges;
        wr(8'h20, 8'h5A);
        idle();
        rd(8'h20, 8'h00, "unmapped");
        wr(8'h0B, 8'hFF);
        rd(8'h0B, 8'hFF, "ones");
        wr(8'h0B, 8'h00);
        rd(8'h0B, 8'h00, "zeros");
    endtask
    // every aux source on both outputs, enables toggled; looked at a half cycle after the lag
    task automatic t_aux;
        for (int i = 0; i < 4; i++) begin
            auxOneSrc <= 2'(i);
            auxTwoSrc <= 2'(3 - i);
            auxOneEn  <= (i % 2 == 0);
            auxTwoEn  <= (i % 2 == 1);
            @(posedge clk_sys);
            @(negedge clk_sys);
            check("auxOne", 8'(auxOneSel), 8'(i));
            check("auxTwo", 8'(auxTwoSel), 8'(3 - i));
            check("auxOneOn", 8'(auxOneOn), 8'(i % 2 == 0));
            check("auxTwoOn", 8'(auxTwoOn), 8'(i % 2 == 1));
            @(posedge clk_sys);
        end
    endtask
    // mid-run reset must throw away what was programmed
    task automatic t_volatile;
        wr(8'h17, 8'h4F);
        wr(8'h48, 8'hA5);
        idle();
        // aux inputs set against the defaults so only reset can give the right outputs
        sys_rst   <= 1'b1;
        auxOneEn  <= 1'b1;
        auxTwoEn  <= 1'b0;
        auxTwoSrc <= ccsb_pkg::AUX_SRC_E;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check("rstAuxTwoOn", 8'(auxTwoOn), 8'h01);
        check("rstAuxTwoSel", 8'(auxTwoSel), 8'(ccsb_pkg::AUX_SRC_REF));
        check("rstAuxOneOn", 8'(auxOneOn), 8'h00);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'h17, 8'h67, "rstLoad");
        rd(8'h48, 8'h8D, "rstSel");
        check("rstOutOn", 8'(synthOutFirstOn), 8'h00);
    endtask
    //--------------------------------------------------------------------------
    // clock and main sequence
    //--------------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        sys_rst = 1'b1;
        {reqValid, reqRead, auxOneEn, err_count, comparisons} = '0;
        {reqAddr, reqData, auxOneSrc, auxTwoSrc} = '0;
        reqCmd = ccsb_pkg::CCSB_CMD_RAW;
        auxTwoEn = 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_defaults();
        t_modes();
        t_audio();
        t_edges();
        t_aux();
        t_volatile();
        final_report();
    end
endmodule
`default_nettype wire
